// [rtl/brk_pkg.sv]
// package with register map, vectors and reset values for the address break unit
// Operation
// - PC match with break address requests breakpoint
// - only CPU program-counter fetches may match
// - finish current instruction, then inject software interrupt
// - vector FFFC/FFFD normally, FEFC/FEFD in monitor
// - writing break active bit forces a break
// - return from interrupt in routine ends break
// - exit flag set when break left stop/wait
// - exit flag cleared by writing zero, reset
// - registers stay accessible during break
// - watchdog held disabled during a break
// - break clear enable zero protects status flags during a break
`default_nettype none
package brk_pkg;
    localparam logic [3:0] ADDR_HIGH_OFS = 4'h0;
    localparam logic [3:0] ADDR_LOW_OFS = 4'h4;
    localparam logic [3:0] CTRL_OFS = 4'h8;
    localparam logic [3:0] STATUS_OFS = 4'hC;
    localparam logic [3:0] FLAG_CTRL_OFS = 4'h0;
    localparam logic [3:0] IRQ_STAT_OFS = 4'h4;
    localparam logic [3:0] IRQ_MASK_OFS = 4'h8;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_ACTIVE_BIT = 6;
    localparam int STATUS_EXIT_BIT = 1;
    localparam int FLAG_CLEAR_EN_BIT = 7;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_SOFT_BIT = 1;
    localparam int IRQ_EXIT_BIT = 2;
    localparam logic [15:0] VECTOR_NORMAL = 16'hFFFC;
    localparam logic [15:0] VECTOR_MONITOR = 16'hFEFC;
    localparam logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h83;
    localparam logic [7:0] RETURN_FROM_INTERRUPT_OPCODE = 8'h80;
endpackage
`default_nettype wire

// [rtl/brk_compare.sv]
// sixteen-bit break address comparator qualified by program-counter fetches
`default_nettype none
module brk_compare #(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic [ADDR_WIDTH-1:0] bus_addr,
    input wire logic pc_fetch,
    input wire logic [ADDR_WIDTH-1:0] break_addr,
    input wire logic enable,
    output logic hit
);
    logic [ADDR_WIDTH-1:0] eq;
    genvar i;
    generate
        for (i = 0; i < ADDR_WIDTH; i = i + 1)
        begin : g_bit
            assign eq[i] = bus_addr[i] ~^ break_addr[i];
        end
    endgenerate
    // data and stack cycles can never hit
    assign hit = enable && pc_fetch && (&eq);
endmodule
`default_nettype wire

// [rtl/address_break_unit.sv]
// address break unit: registers, break sequencing, exit flag and interrupt
//
// The register offsets and the Wishbone register port are this design's own decisions.
`default_nettype none
module address_break_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_pc_fetch,
    input wire logic cpu_instr_done,
    input wire logic [7:0] cpu_opcode,
    input wire logic cpu_lowpower,
    input wire logic monitor_mode,
    output logic breakpoint_request,
    output logic inject_opcode_valid,
    output logic [7:0] inject_opcode,
    output logic [15:0] vector_addr,
    output logic break_state,
    output logic watchdog_disable,
    output logic status_clear_allow,
    output logic irq
);
    import brk_pkg::*;

    typedef struct packed {
        logic [7:0] addr_high_reg;
        logic [7:0] addr_low_reg;
        logic enable_reg;
        logic pending_reg;
        logic in_break_reg;
        logic exit_flag_reg;
        logic clear_en_reg;
        logic [2:0] irq_stat_reg;
        logic [2:0] irq_mask_reg;
        logic ack_reg;
        logic [31:0] rdata_reg;
        logic inject_reg;
        logic [15:0] vector_reg;
    } state_type;

    state_type s_reg;
    state_type s_next;
    logic hit;
    logic access;
    logic wr;
    logic rd;
    logic bank;
    logic [3:0] ofs;
    logic [7:0] wbyte;
    logic soft_break;
    logic rti_seen;
    logic [7:0] ctrl_view;
    logic [7:0] status_view;

    brk_compare #(
        .ADDR_WIDTH(16)
    ) u_cmp (
        .bus_addr(cpu_addr),
        .pc_fetch(cpu_pc_fetch),
        .break_addr({s_reg.addr_high_reg, s_reg.addr_low_reg}),
        .enable(s_reg.enable_reg),
        .hit(hit)
    );

    // one-cycle answer, then ack drops for a cycle
    assign access = wb_cyc_i && wb_stb_i && !s_reg.ack_reg;
    assign wr = access && wb_we_i && wb_sel_i[0];
    assign rd = access && !wb_we_i;
    assign bank = wb_adr_i[4];
    assign ofs = wb_adr_i[3:0];
    assign wbyte = wb_dat_i[7:0];
    assign soft_break = wr && !bank && ofs == CTRL_OFS && wbyte[CTRL_ACTIVE_BIT];
    assign rti_seen = s_reg.in_break_reg && cpu_instr_done
        && cpu_opcode == RETURN_FROM_INTERRUPT_OPCODE;
    assign ctrl_view = {s_reg.enable_reg, s_reg.in_break_reg | s_reg.pending_reg, 6'h00};
    assign status_view = {6'h00, s_reg.exit_flag_reg, 1'b0};

    always_comb
    begin
        s_next = s_reg;
        s_next.ack_reg = access;
        // registers stay reachable regardless of break state
        if (wr)
        begin
            if (!bank)
            begin
                unique case (ofs)
                    ADDR_HIGH_OFS: s_next.addr_high_reg = wbyte;
                    ADDR_LOW_OFS: s_next.addr_low_reg = wbyte;
                    CTRL_OFS: s_next.enable_reg = wbyte[CTRL_ENABLE_BIT];
                    STATUS_OFS:
                    begin
                        // only a zero clears; writing one has no effect
                        // a protected break leaves the flag for the routine to inspect
                        if (!wbyte[STATUS_EXIT_BIT] && status_clear_allow)
                        begin
                            s_next.exit_flag_reg = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            else
            begin
                unique case (ofs)
                    FLAG_CTRL_OFS: s_next.clear_en_reg = wbyte[FLAG_CLEAR_EN_BIT];
                    IRQ_MASK_OFS: s_next.irq_mask_reg = wbyte[2:0];
                    default: ;
                endcase
            end
        end
        s_next.rdata_reg = 32'h0000_0000;
        if (rd)
        begin
            if (!bank)
            begin
                unique case (ofs)
                    ADDR_HIGH_OFS: s_next.rdata_reg = {24'h000000, s_reg.addr_high_reg};
                    ADDR_LOW_OFS: s_next.rdata_reg = {24'h000000, s_reg.addr_low_reg};
                    CTRL_OFS: s_next.rdata_reg = {24'h000000, ctrl_view};
                    STATUS_OFS: s_next.rdata_reg = {24'h000000, status_view};
                    default: s_next.rdata_reg = 32'h0000_0000;
                endcase
            end
            else
            begin
                unique case (ofs)
                    FLAG_CTRL_OFS:
                        s_next.rdata_reg = {24'h000000, s_reg.clear_en_reg, 7'h00};
                    IRQ_STAT_OFS: s_next.rdata_reg = {29'h0, s_reg.irq_stat_reg};
                    IRQ_MASK_OFS: s_next.rdata_reg = {29'h0, s_reg.irq_mask_reg};
                    default: s_next.rdata_reg = 32'h0000_0000;
                endcase
            end
        end
        // interrupt status is read-to-clear; events below win over the clear
        if (rd && bank && ofs == IRQ_STAT_OFS && status_clear_allow)
        begin
            s_next.irq_stat_reg = 3'b000;
        end
        if (hit || soft_break)
        begin
            s_next.pending_reg = 1'b1;
        end
        s_next.inject_reg = 1'b0;
        // wait for the running instruction to retire before injecting
        if (s_reg.pending_reg && cpu_instr_done && !s_reg.in_break_reg)
        begin
            s_next.pending_reg = 1'b0;
            s_next.in_break_reg = 1'b1;
            s_next.inject_reg = 1'b1;
            s_next.vector_reg = monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL;
            if (cpu_lowpower)
            begin
                s_next.exit_flag_reg = 1'b1;
                s_next.irq_stat_reg[IRQ_EXIT_BIT] = 1'b1;
            end
        end
        if (rti_seen)
        begin
            s_next.in_break_reg = 1'b0;
        end
        if (hit)
        begin
            s_next.irq_stat_reg[IRQ_MATCH_BIT] = 1'b1;
        end
        if (soft_break)
        begin
            s_next.irq_stat_reg[IRQ_SOFT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.addr_high_reg <= ADDR_RESET;
            s_reg.addr_low_reg <= ADDR_RESET;
            s_reg.vector_reg <= VECTOR_NORMAL;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o = s_reg.ack_reg;
    assign wb_dat_o = s_reg.rdata_reg;
    assign breakpoint_request = s_reg.pending_reg;
    assign inject_opcode_valid = s_reg.inject_reg;
    assign inject_opcode = SOFTWARE_INTERRUPT_OPCODE;
    assign vector_addr = s_reg.vector_reg;
    assign break_state = s_reg.in_break_reg;
    assign watchdog_disable = s_reg.in_break_reg | s_reg.pending_reg;
    // flags elsewhere may only be cleared in break when enabled
    assign status_clear_allow = !s_reg.in_break_reg || s_reg.clear_en_reg;
    assign irq = |(s_reg.irq_stat_reg & s_reg.irq_mask_reg);
endmodule
`default_nettype wire

// [verification/break_props.sv]
// concurrent checks on the address break unit ports
`default_nettype none
module break_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic cpu_pc_fetch,
    input wire logic cpu_instr_done,
    input wire logic [7:0] cpu_opcode,
    input wire logic monitor_mode,
    input wire logic breakpoint_request,
    input wire logic inject_opcode_valid,
    input wire logic [7:0] inject_opcode,
    input wire logic [15:0] vector_addr,
    input wire logic break_state,
    input wire logic watchdog_disable
);
    timeunit 1ns;
    timeprecision 1ns;
    import brk_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence take_s;
        breakpoint_request && cpu_instr_done && !break_state;
    endsequence
    sequence enter_s;
        inject_opcode_valid && break_state && inject_opcode == SOFTWARE_INTERRUPT_OPCODE;
    endsequence
    property p_inject_cause;
        inject_opcode_valid |-> $past(breakpoint_request && cpu_instr_done && !break_state)
            && inject_opcode == SOFTWARE_INTERRUPT_OPCODE;
    endproperty
    property p_vector_sel;
        inject_opcode_valid
            |-> vector_addr == ($past(monitor_mode) ? VECTOR_MONITOR : VECTOR_NORMAL);
    endproperty
    property p_rti_ends;
        break_state && cpu_instr_done && cpu_opcode == RETURN_FROM_INTERRUPT_OPCODE
            |=> !break_state;
    endproperty
    property p_no_stray;
        !cpu_pc_fetch && !wb_we_i && !breakpoint_request && !break_state && !$past(break_state)
            |=> !breakpoint_request;
    endproperty
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_take_inject: assert property (take_s |=> enter_s)
        else $error("no injection");
    a_inject_cause: assert property (p_inject_cause)
        else $error("stray injection");
    a_vector_sel: assert property (p_vector_sel)
        else $error("bad vector");
    a_rti_ends: assert property (p_rti_ends)
        else $error("break kept");
    a_wdog_hold: assert property (breakpoint_request || break_state |-> watchdog_disable)
        else $error("watchdog on");
    a_no_stray: assert property (p_no_stray)
        else $error("stray request");
endmodule
bind address_break_unit break_props u_props (.*);
`default_nettype wire

// [verification/cpu_model.sv]
// cpu stand-in: fetch cycle then execute cycle with data access
`default_nettype none
module cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic return_from_interrupt_opcode,
    input wire logic inject_opcode_valid,
    input wire logic [15:0] vector_addr,
    output logic [15:0] cpu_addr,
    output logic cpu_pc_fetch,
    output logic cpu_instr_done,
    output logic [7:0] cpu_opcode
);
    timeunit 1ns;
    timeprecision 1ns;
    import brk_pkg::*;
    logic [15:0] pc;
    logic ph;
    // data cycles sit in the far half of memory, never a fetch address
    assign cpu_addr = ph ? pc ^ 16'h8000 : pc;
    assign cpu_pc_fetch = !ph;
    assign cpu_instr_done = ph;
    assign cpu_opcode = return_from_interrupt_opcode ? RETURN_FROM_INTERRUPT_OPCODE : 8'h9D;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            {pc, ph} <= 17'h00000;
        else
        begin
            ph <= !ph;
            if (inject_opcode_valid)
                pc <= vector_addr;
            else if (ph)
                pc <= pc + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the address break unit
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import brk_pkg::*;
    logic clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic cpu_lowpower = 0, monitor_mode = 0, return_from_interrupt_opcode = 0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_d;
    logic wb_ack_o, cpu_pc_fetch, cpu_instr_done, breakpoint_request, inject_opcode_valid;
    logic break_state, watchdog_disable, status_clear_allow, irq;
    logic [7:0] cpu_opcode, inject_opcode;
    logic [15:0] cpu_addr, vector_addr, na;
    int failures = 0, comparisons = 0;
    always #50 clk = ~clk;
    address_break_unit u_dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_addr(cpu_addr),
        .cpu_pc_fetch(cpu_pc_fetch), .cpu_instr_done(cpu_instr_done), .cpu_opcode(cpu_opcode),
        .cpu_lowpower(cpu_lowpower), .monitor_mode(monitor_mode),
        .breakpoint_request(breakpoint_request), .inject_opcode_valid(inject_opcode_valid),
        .inject_opcode(inject_opcode), .vector_addr(vector_addr), .break_state(break_state),
        .watchdog_disable(watchdog_disable), .status_clear_allow(status_clear_allow),
        .irq(irq)
    );
    cpu_model u_cpu (
        .clk(clk), .rst_n(rst_n), .return_from_interrupt_opcode(return_from_interrupt_opcode), .inject_opcode_valid(inject_opcode_valid),
        .vector_addr(vector_addr), .cpu_addr(cpu_addr), .cpu_pc_fetch(cpu_pc_fetch),
        .cpu_instr_done(cpu_instr_done), .cpu_opcode(cpu_opcode)
    );
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd_d = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task rdc(input string n, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(n, {24'h0, e}, rd_d);
    endtask
    // low byte first so a half-written address never lands on live code
    task setaddr(input logic [15:0] v);
        bus(1'b1, 5'h04, v[7:0]);
        bus(1'b1, 5'h00, v[15:8]);
    endtask
    // ca: expected clear permission in break, st: irq status seen inside the break
    task brk(input logic [15:0] v, input logic ca, input logic [7:0] st);
        for (int i = 0; i < 300 && break_state !== 1'b1; i++) @(posedge clk);
        chk("break_on", 1, break_state);
        chk("vector", {16'h0, v}, {16'h0, vector_addr});
        chk("watchdog", 1, watchdog_disable);
        chk("clear_allow", {31'h0, ca}, status_clear_allow);
        rdc("addr_low", 5'h04, na[7:0]);
        rdc("irq_in_break", 5'h14, st);
        return_from_interrupt_opcode <= 1'b1;
        for (int i = 0; i < 300 && break_state !== 1'b0; i++) @(posedge clk);
        return_from_interrupt_opcode <= 1'b0;
        chk("break_end", 0, break_state);
    endtask
    task print_verdict;
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk("rst_vector", {16'h0, VECTOR_NORMAL}, {16'h0, vector_addr});
        chk("rst_clear_allow", 1, status_clear_allow);
        chk("rst_irq", 0, irq);
        rdc("ctrl", 5'h08, 8'h00);
        rdc("status", 5'h0C, 8'h00);
        rdc("unmapped", 5'h1C, 8'h00);
        setaddr(16'hA53C);
        rdc("addr_high", 5'h00, 8'hA5);
        rdc("addr_low", 5'h04, 8'h3C);
        bus(1'b1, 5'h18, 8'h07);
        bus(1'b1, 5'h08, 8'h80);
        na = u_cpu.pc + 16'h0010;
        setaddr(na ^ 16'h8000);
        repeat (60) @(posedge clk);
        chk("data_no_break", 0, breakpoint_request | break_state);
        na = u_cpu.pc + 16'h0010;
        setaddr(na);
        // protected break: the status read inside must not clear the match bit
        brk(VECTOR_NORMAL, 1'b0, 8'h01);
        chk("irq_on", 1, irq);
        rdc("irq_stat", 5'h14, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq_off", 0, irq);
        rdc("exit_none", 5'h0C, 8'h00);
        bus(1'b1, 5'h10, 8'h80);
        rdc("clear_en", 5'h10, 8'h80);
        cpu_lowpower <= 1'b1;
        monitor_mode <= 1'b1;
        bus(1'b1, 5'h08, 8'hC0);
        brk(VECTOR_MONITOR, 1'b1, 8'h06);
        cpu_lowpower <= 1'b0;
        rdc("exit_flag", 5'h0C, 8'h02);
        rdc("irq_stat2", 5'h14, 8'h00);
        bus(1'b1, 5'h0C, 8'h02);
        rdc("exit_keep", 5'h0C, 8'h02);
        bus(1'b1, 5'h0C, 8'h00);
        rdc("exit_clear", 5'h0C, 8'h00);
        print_verdict;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        print_verdict;
    end
endmodule
`default_nettype wire
